// ===== hdl/cmpce_top.sv
// Control register, event logic and interrupt for one comparator channel.
// Assumes the analog comparator output arrives asynchronously on a pin.
//
// Our own choices: the register offsets and the address-and-strobe port.
module cmpce_top
	import cmpce_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [3:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic comparator_raw_in,
	output logic [15:0] rdata_out,
	output logic [7:0] analog_ctl_out,
	output logic result_pin_out,
	output logic result_pin_oe_out,
	output logic irq_out
);

	////////////////////////////////////////////////////////////////////////
	// Bus decode
	cmpce_bus_t bus;
	assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

	wire wr_control = bus.wr && (bus.addr == CMPCE_ADDR_CONTROL);
	wire wr_status = bus.wr && (bus.addr == CMPCE_ADDR_IRQ_STATUS);
	wire wr_mask = bus.wr && (bus.addr == CMPCE_ADDR_IRQ_MASK);

	logic [15:0] control;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;
	logic result_prev;
	logic first_done;
	logic raw_sync;

	cmpce_sync u_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.async_in(comparator_raw_in),
		.sync_out(raw_sync)
	);

	////////////////////////////////////////////////////////////////////////
	// Result path
	wire enabled = control[CMPCE_BIT_ENABLE];
	wire cmpce_edge_t edge_sel = cmpce_edge_t'(control[CMPCE_EDGE_LSB +: 2]);
	wire result = enabled & (raw_sync ^ control[CMPCE_BIT_INVERT]);

	wire rise = result & ~result_prev;
	wire fall = ~result & result_prev;
	wire change = result ^ result_prev;

	wire edge_match = (edge_sel == CMPCE_EDGE_RISE) ? rise :
		(edge_sel == CMPCE_EDGE_FALL) ? fall :
		(edge_sel == CMPCE_EDGE_ANY) ? change : 1'b0;
	wire trig_cond = first_done ? edge_match : change;
	wire trigger = enabled && (edge_sel != CMPCE_EDGE_OFF) && trig_cond &&
		!control[CMPCE_BIT_EVENT];

	// Software clear wins over an edge in the same cycle; trigger is blocked while the event flag is set
	// writable mask, result read-only
	wire [15:0] next_control_w = wr_control ? (bus.wdata & CMPCE_CONTROL_WMASK) :
		(control & CMPCE_CONTROL_WMASK);
	wire [15:0] next_control = next_control_w |
		({15'h0000, trigger} << CMPCE_BIT_EVENT);

	// Any edge selection change rearms the first-interrupt rule
	wire edge_rewrite = wr_control &&
		(bus.wdata[CMPCE_EDGE_LSB +: 2] != control[CMPCE_EDGE_LSB +: 2]);
	wire next_first_done = edge_rewrite ? 1'b0 : (first_done | trigger);

	wire [1:0] irq_set = {enabled & change, trigger};
	wire [1:0] next_irq_status = (irq_status & ~(wr_status ? bus.wdata[1:0] : 2'h0)) |
		irq_set;

	wire [15:0] control_view = {control[15:9], result, control[7:0]};
	wire [15:0] next_rdata = !bus.rd ? 16'h0000 :
		(bus.addr == CMPCE_ADDR_CONTROL) ? control_view :
		(bus.addr == CMPCE_ADDR_IRQ_STATUS) ? {14'h0000, irq_status} :
		(bus.addr == CMPCE_ADDR_IRQ_MASK) ? {14'h0000, irq_mask} : 16'h0000;

	cmpce_analog_ctl_t next_analog;
	assign next_analog = '{
		channel_enable: next_control[CMPCE_BIT_ENABLE],
		output_pin_enable: next_control[CMPCE_BIT_PIN_EN],
		output_invert: next_control[CMPCE_BIT_INVERT],
		low_power_select: next_control[CMPCE_BIT_LOW_POWER],
		positive_input_select: next_control[CMPCE_PSEL_LSB +: 2],
		negative_input_select: next_control[CMPCE_NSEL_LSB +: 2]
	};

	////////////////////////////////////////////////////////////////////////
	// State
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			control <= CMPCE_CONTROL_RESET;
			irq_status <= CMPCE_IRQ_RESET;
			irq_mask <= CMPCE_IRQ_RESET;
			result_prev <= 1'b0;
			first_done <= 1'b0;
		end else begin
			control <= next_control;
			irq_status <= next_irq_status;
			irq_mask <= wr_mask ? bus.wdata[1:0] : irq_mask;
			result_prev <= result;
			first_done <= next_first_done;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered outputs
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rdata_out <= 16'h0000;
			analog_ctl_out <= 8'h00;
			result_pin_out <= 1'b0;
			result_pin_oe_out <= 1'b0;
			irq_out <= 1'b0;
		end else begin
			rdata_out <= next_rdata;
			analog_ctl_out <= next_analog;
			result_pin_out <= result & control[CMPCE_BIT_PIN_EN];
			result_pin_oe_out <= enabled & control[CMPCE_BIT_PIN_EN];
			irq_out <= |(next_irq_status & irq_mask);
		end
	end

endmodule

// ===== hdl/cmpce_pkg.sv
// Constants, field layout and carrier types for the comparator control block.
// Assumes one 10 MHz clock and a synchronous active-high reset.
package cmpce_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register map
	localparam logic [3:0] CMPCE_ADDR_CONTROL = 4'h0;
	localparam logic [3:0] CMPCE_ADDR_IRQ_STATUS = 4'h1;
	localparam logic [3:0] CMPCE_ADDR_IRQ_MASK = 4'h2;
	localparam logic [15:0] CMPCE_CONTROL_RESET = 16'h0000;
	localparam logic [15:0] CMPCE_CONTROL_WMASK = 16'hf2db;
	localparam logic [1:0] CMPCE_IRQ_RESET = 2'h0;

	////////////////////////////////////////////////////////////////////////
	// Control field positions
	localparam int CMPCE_BIT_ENABLE = 15;
	localparam int CMPCE_BIT_PIN_EN = 14;
	localparam int CMPCE_BIT_INVERT = 13;
	localparam int CMPCE_BIT_LOW_POWER = 12;
	localparam int CMPCE_BIT_EVENT = 9;
	localparam int CMPCE_BIT_RESULT = 8;
	localparam int CMPCE_EDGE_LSB = 6;
	localparam int CMPCE_PSEL_LSB = 3;
	localparam int CMPCE_NSEL_LSB = 0;

	// Interrupt status bits: event, any result change
	localparam int CMPCE_IRQ_EVENT = 0;
	localparam int CMPCE_IRQ_CHANGE = 1;

	typedef enum logic [1:0] {
		CMPCE_EDGE_OFF = 2'h0,
		CMPCE_EDGE_RISE = 2'h1,
		CMPCE_EDGE_FALL = 2'h2,
		CMPCE_EDGE_ANY = 2'h3
	} cmpce_edge_t;

	typedef struct packed {
		logic channel_enable;
		logic output_pin_enable;
		logic output_invert;
		logic low_power_select;
		logic [1:0] positive_input_select;
		logic [1:0] negative_input_select;
	} cmpce_analog_ctl_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} cmpce_bus_t;

endpackage

// ===== hdl/cmpce_sync.sv
// Two-stage synchroniser for the raw comparator level.
// Assumes the input is asynchronous to clk_in.
module cmpce_sync
	import cmpce_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic async_in,
	output logic sync_out
);

	logic stage1;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			stage1 <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end

endmodule

// ===== testbench/cmpce_comp_model.sv
// Behavioural comparator feeding cmpce_top.
// Assumes millivolt levels as 12-bit codes.
module cmpce_comp_model #(parameter logic [11:0] VREF = 12'h4b0) (
	input wire logic [7:0] ctl_in,
	input wire logic [11:0] pin_a_in,
	input wire logic [11:0] neg_in,
	output logic raw_out
);
	timeunit 1ns;
	timeprecision 1ns;
	wire logic [11:0] pos = ctl_in[3:2] == 2'h0 ? pin_a_in : VREF;
	// Settling lag keeps edges off clk
	assign #37 raw_out = pos > neg_in;
endmodule

// ===== testbench/cmpce_properties.sv
// Port properties of cmpce_top.
// Assumes one clock, synchronous reset.
module cmpce_properties (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [3:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [15:0] rdata_out,
	input wire logic [7:0] analog_ctl_out,
	input wire logic result_pin_out,
	input wire logic result_pin_oe_out,
	input wire logic irq_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	logic [15:0] w_q;
	always_ff @(posedge clk_in) begin
		w_q <= wdata_in;
	end
	wire logic rd0 = rd_in && addr_in == 4'h0;
	wire logic wm = wr_in && addr_in == 4'h2;
	property p_ctl;
		wr_in && addr_in == 4'h0 |=> analog_ctl_out == {w_q[15:12], w_q[4:3], w_q[1:0]};
	endproperty
	property p_off; $fell(analog_ctl_out[7]) |=> !result_pin_oe_out; endproperty
	property p_pin; !result_pin_oe_out |-> !result_pin_out; endproperty
	property p_gap; rd0 |=> rdata_out[11:10] == 2'h0 && !rdata_out[5] && !rdata_out[2]; endproperty
	property p_dis; rd0 |=> rdata_out[15] || !rdata_out[8]; endproperty
	property p_irq; wm && wdata_in[1:0] == 2'h0 |=> wm or ##1 !irq_out; endproperty
	property p_rst; $fell(rst_in) |-> rdata_out == 16'h0 && !irq_out && !analog_ctl_out; endproperty
	property p_unm; rd_in && addr_in > 4'h2 |=> rdata_out == 16'h0; endproperty
	a_ctl: assert property (p_ctl) else $error("ctl fields");
	a_off: assert property (p_off) else $error("pin on");
	a_pin: assert property (p_pin) else $error("pin");
	a_gap: assert property (p_gap) else $error("gap bits");
	a_dis: assert property (p_dis) else $error("result");
	a_irq: assert property (p_irq) else $error("irq");
	a_rst: assert property (p_rst) else $error("reset");
	a_unm: assert property (p_unm) else $error("unmapped");
	c_irq: cover property ($rose(irq_out));
	c_pin: cover property (result_pin_oe_out && result_pin_out);
	c_evt: cover property (rd0 ##1 rdata_out[9]);
endmodule
bind cmpce_top cmpce_properties u_chk (.clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
	.rdata_out, .analog_ctl_out, .result_pin_out, .result_pin_oe_out, .irq_out);

// ===== testbench/testbench.sv
// Self-checking bench for cmpce_top.
// Assumes the comparator model and bound checker.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 1'h0, rst_in = 1'h1, wr_in = 1'h0, rd_in = 1'h0, raw, pin, oe, irq;
	logic [3:0] addr_in = 4'h0;
	logic [15:0] wdata_in = 16'h0, rdata;
	logic [7:0] actl;
	logic [11:0] pin_a = 12'h7d0;
	int bad_count = 0, tests_run = 0, cyc = 0;
	always #50 clk_in = ~clk_in;
	cmpce_top u_dut (.clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
		.comparator_raw_in(raw), .rdata_out(rdata), .analog_ctl_out(actl),
		.result_pin_out(pin), .result_pin_oe_out(oe), .irq_out(irq));
	cmpce_comp_model u_cmp (.ctl_in(actl), .pin_a_in(pin_a), .neg_in(12'h5dc), .raw_out(raw));
	task automatic chk(string n, logic [15:0] s, logic [15:0] e);
		tests_run++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(logic [3:0] a, logic [15:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'h1;
		@(posedge clk_in);
		wr_in <= 1'h0;
	endtask
	task automatic rchk(string n, logic [3:0] a, logic [15:0] m, logic [15:0] e);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'h1;
		@(posedge clk_in);
		rd_in <= 1'h0;
		@(negedge clk_in);
		chk(n, rdata & m, e);
	endtask
	task automatic level(logic [11:0] v);
		pin_a <= v;
		repeat (6) @(negedge clk_in);
	endtask
	task automatic t_reg;
		rchk("ctl rst", 4'h0, 16'hffff, 16'h0);
		wr(4'h0, 16'h7fff);
		rchk("ctl rw", 4'h0, 16'hffff, 16'h72db);
		chk("analog", {8'h0, actl}, 16'h7f);
		rchk("unmapped", 4'h7, 16'hffff, 16'h0);
		$display("t_reg done");
	endtask
	task automatic t_res;
		logic [15:0] c[5] = '{16'h0, 16'h8000, 16'ha000, 16'h8008, 16'ha008};
		logic [15:0] e[5] = '{16'h0, 16'h100, 16'h0, 16'h0, 16'h100};
		foreach (c[i]) begin
			wr(4'h0, c[i]);
			// Input select reaches the result through the two-flop sync
			repeat (3) @(posedge clk_in);
			rchk("result", 4'h0, 16'h100, e[i]);
		end
		wr(4'h0, 16'hc000);
		level(12'h7d0);
		chk("pin on", {14'h0, oe, pin}, 16'h3);
		wr(4'h0, 16'h4000);
		level(12'h7d0);
		chk("pin off", {14'h0, oe, pin}, 16'h0);
		$display("t_res done");
	endtask
	task automatic t_evt;
		wr(4'h2, 16'h1);
		wr(4'h0, 16'h8000);
		level(12'h7d0);
		for (int k = 0; k < 4; k++) begin
			wr(4'h0, 16'h8000 | 16'(k << 6));
			level(12'h3e8);
			rchk("flag", 4'h0, 16'h200, k ? 16'h200 : 16'h0);
			chk("irq", {15'h0, irq}, k ? 16'h1 : 16'h0);
			wr(4'h1, 16'h3);
			wr(4'h0, 16'h8000);
			level(12'h7d0);
			chk("irq clr", {15'h0, irq}, 16'h0);
		end
		wr(4'h0, 16'h8040);
		level(12'h3e8);
		wr(4'h0, 16'h8040);
		level(12'h7d0);
		rchk("rise", 4'h0, 16'h200, 16'h200);
		wr(4'h0, 16'h8040);
		wr(4'h2, 16'h0);
		level(12'h3e8);
		rchk("fall", 4'h0, 16'h200, 16'h0);
		chk("masked", {15'h0, irq}, 16'h0);
		rchk("status", 4'h1, 16'hffff, 16'h3);
		$display("t_evt done");
	endtask
	task automatic t_rst;
		wr(4'h2, 16'h3);
		wr(4'h0, 16'hf2db);
		@(posedge clk_in);
		rst_in <= 1'h1;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'h0;
		@(negedge clk_in);
		chk("oe rst", {15'h0, oe}, 16'h0);
		rchk("ctl rst2", 4'h0, 16'hffff, 16'h0);
		rchk("mask rst", 4'h2, 16'hffff, 16'h0);
		$display("t_rst done");
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk_in);
		rst_in <= 1'h0;
		t_reg;
		t_res;
		t_evt;
		t_rst;
		give_verdict;
	end
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			give_verdict;
		end
	end
endmodule
